// file: src/i2cu_unit.sv
// Two-wire bus unit: master engine, slave clock stretch, register file
//
// How it works
// - One role at a time; select bit 0 master (reset), 1 slave.
// - Master offers 100 kbps, 400 kbps and 1 Mbps bus rates.
// - Master uses 7-bit addresses; slave decodes no address; neither offers 10-bit addressing.
// - Master syncs to the bus clock; slave stretches clock in wait.
// - Master receive byte is read-only, updated after each full byte.
// - Data sampled at the end of the first clock-high quarter of every bit, so sent bits are captured too.
// - Target address in bits 7-1, bit 0 direction: 0 send, 1 receive.
// - Start bit 1 begins start plus address; 0 aborts at once.
// - After acknowledge master waits; start bit 1 resumes next byte.
// - Start bit accepts a 1 only while master enable is set.
// - Stop request makes a stop, clears start bit, reads as 0.
// - Restart request repeats start from address, only if start set.
// - Master drives control bit 7 as acknowledge after received bytes.
// - Master mode register resets to 0x0200 with its listed fields.
// - Enable allows start and busy flag; clearing it resets the master data registers.
// - Word registers take word access at even addresses only.
// - Rate field 00 standard, 01 fast, 11 one megabit.
// - Clock field picks high or low speed clock and its divider.
// - Slow-down 0 to 30 percent, forced off on low-speed clock.
// - Busy flag sets on start, clears on stop, write 1 clears.
module i2cu_unit import i2cu_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Avalon-MM register slave, word index addressing
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Low-speed clock enable from the clock generator
  input wire logic low_speed_tick,
  // Serial clock pin, open drain
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  // Serial data pin, open drain
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe
);

  typedef struct packed {
    logic role;
    logic [7:0] mrx, maddr, mtx;
    logic ack_val, start;
    logic [15:0] mode;
    logic busy, ackr, err;
    logic [7:0] srx, sown, stx;
    logic sact;
    logic [7:0] smode, ssta;
    logic wreq;
    logic [31:0] rdata;
    i2cu_state_t state;
    logic [3:0] bitn;
    logic [1:0] phase;
    logic [7:0] shift, sh_in;
    logic is_addr, scl_oe, sda_oe;
    logic sda_s1, sda_s2, scl_s1, scl_s2, sda_d, scl_d;
    logic [3:0] s_cnt;
    logic s_act, s_stretch;
    logic [7:0] s_sh;
  } i2cu_core_t;

  i2cu_core_t q, n;
  logic qtick, run, clear, en, sync_on, tx_phase, drive_bit, hold;
  logic start_seen, stop_seen, scl_rise, scl_fall;
  logic acc, lo, hi;
  logic [7:0] wd;
  logic [15:0] rd16;

  // Bit timing runs only while a bus phase is in progress
  i2cu_bit_timer u_timer (
    .clk(clk),
    .srst(srst),
    .clk_sel(q.mode[MODE_CLK_LO +: 3]),
    .rate_sel(q.mode[MODE_RATE_LO +: 2]),
    .slow_sel(q.mode[MODE_SLOW_LO +: 2]),
    .low_speed_tick(low_speed_tick),
    .run(run),
    .clear(clear),
    .quarter_tick(qtick)
  );

  // Next state of the whole unit
  always_comb begin
    n = q;
    en = q.mode[MODE_EN];
    sync_on = q.mode[MODE_SYNC];
    wd = avs_writedata[7:0];

    // Pin synchronisers, then edge and condition detection on stage two
    n.sda_s1 = serial_data_pin_in;
    n.sda_s2 = q.sda_s1;
    n.sda_d = q.sda_s2;
    n.scl_s1 = serial_clock_pin_in;
    n.scl_s2 = q.scl_s1;
    n.scl_d = q.scl_s2;
    start_seen = q.scl_s2 && q.scl_d && q.sda_d && !q.sda_s2;
    stop_seen = q.scl_s2 && q.scl_d && !q.sda_d && q.sda_s2;
    scl_rise = q.scl_s2 && !q.scl_d;
    scl_fall = !q.scl_s2 && q.scl_d;

    // Register bus: one wait cycle, then a one-cycle answer
    acc = (avs_read || avs_write) && !q.wreq;
    lo = avs_write && acc && avs_byteenable[0];
    hi = avs_write && acc && avs_byteenable[1];
    n.wreq = !((avs_read || avs_write) && q.wreq);
    case (avs_address)
      REG_ROLE: rd16 = {15'h0000, q.role};
      REG_MRX: rd16 = {8'h00, q.mrx};
      REG_MADDR: rd16 = {8'h00, q.maddr};
      REG_MTX: rd16 = {8'h00, q.mtx};
      REG_MCTRL: rd16 = {8'h00, q.ack_val, 6'h00, q.start};
      REG_MMODE: rd16 = q.mode;
      REG_MSTA: rd16 = {13'h0000, q.err, q.ackr, q.busy};
      REG_SRX: rd16 = {8'h00, q.srx};
      REG_SOWN: rd16 = {8'h00, q.sown};
      REG_STX: rd16 = {8'h00, q.stx};
      REG_SCTRL: rd16 = {8'h00, q.sact, 7'h00};
      REG_SMODE: rd16 = {8'h00, q.smode};
      REG_SSTA: rd16 = {8'h00, q.ssta};
      default: rd16 = 16'h0000;
    endcase
    n.rdata = {16'h0000, rd16};

    // Status flags clear on a written 1; later hardware sets win
    if (lo && avs_address == REG_MSTA) begin
      if (wd[STA_BUSY]) begin
        n.busy = 1'b0;
      end
      if (wd[STA_ACK]) begin
        n.ackr = 1'b0;
      end
      if (wd[STA_ERR]) begin
        n.err = 1'b0;
      end
    end

    // Master line drive, one quarter phase at a time
    tx_phase = q.is_addr || !q.maddr[ADDR_DIR];
    if (q.bitn < ACK_BIT_IDX) begin
      drive_bit = tx_phase && !q.shift[7];
    end else begin
      drive_bit = !tx_phase && !q.ack_val;
    end
    hold = sync_on && q.phase[1] && !q.scl_s2 && q.state != ST_IDLE
      && q.state != ST_WAIT;
    run = !hold;
    clear = q.state == ST_IDLE || q.state == ST_WAIT;
    case (q.state)
      ST_START: begin
        n.scl_oe = 1'b0;
        n.sda_oe = q.phase[1];
      end
      ST_XFER: begin
        n.scl_oe = !q.phase[1];
        if (q.phase != PH_LOW0) begin
          n.sda_oe = drive_bit; // Data moves only while the clock is low
        end
      end
      ST_WAIT: begin
        n.scl_oe = 1'b1;
      end
      ST_RESTART: begin
        n.scl_oe = !q.phase[1];
        if (q.phase != PH_LOW0) begin
          n.sda_oe = 1'b0;
        end
      end
      ST_STOP: begin
        n.scl_oe = !q.phase[1];
        if (q.phase != PH_LOW0) begin
          n.sda_oe = q.phase != PH_HIGH1;
        end
      end
      default: begin
        n.scl_oe = 1'b0;
        n.sda_oe = 1'b0;
      end
    endcase

    // Master sequencing on quarter ticks
    if (qtick && q.state != ST_IDLE && q.state != ST_WAIT) begin
      n.phase = q.phase + 2'h1;
      case (q.state)
        ST_START: begin
          if (q.phase == PH_HIGH1) begin
            n.state = ST_XFER;
            n.bitn = 4'h0;
            n.is_addr = 1'b1;
            n.shift = q.maddr;
          end
        end
        ST_XFER: begin
          if (q.phase == PH_HIGH0) begin
            if (q.bitn < ACK_BIT_IDX) begin
              n.sh_in = {q.sh_in[6:0], q.sda_s2};
              if (q.bitn == LAST_DATA_IDX) begin
                n.mrx = {q.sh_in[6:0], q.sda_s2};
              end
              if (tx_phase && q.shift[7] && !q.sda_s2) begin
                n.err = 1'b1;
              end
            end else begin
              n.ackr = q.sda_s2;
            end
          end
          if (q.phase == PH_HIGH1) begin
            if (q.bitn == ACK_BIT_IDX) begin
              n.state = ST_WAIT;
              n.bitn = 4'h0;
            end else begin
              n.bitn = q.bitn + 4'h1;
              n.shift = {q.shift[6:0], 1'b0};
            end
          end
        end
        ST_RESTART: begin
          if (q.phase == PH_HIGH1) begin
            n.state = ST_START;
          end
        end
        ST_STOP: begin
          if (q.phase == PH_HIGH1) begin
            n.state = ST_IDLE;
          end
        end
        default: begin
          n.state = ST_IDLE;
        end
      endcase
    end

    // Bus busy follows conditions seen on the wire while enabled
    if (en) begin
      if (start_seen) begin
        n.busy = 1'b1;
      end else if (stop_seen) begin
        n.busy = 1'b0;
      end
    end else begin
      n.busy = 1'b0;
    end

    // Plain register writes
    if (lo) begin
      case (avs_address)
        REG_ROLE: n.role = wd[ROLE_BIT];
        REG_MADDR: n.maddr = wd;
        REG_MTX: n.mtx = wd;
        REG_MMODE: n.mode[7:0] = wd & MODE_WMASK[7:0];
        REG_SOWN: n.sown = wd;
        REG_STX: n.stx = wd;
        REG_SCTRL: n.sact = wd[SCTL_ACK];
        REG_SMODE: n.smode = wd;
        REG_SSTA: n.ssta = wd;
        default: n.role = n.role;
      endcase
    end
    if (hi && avs_address == REG_MMODE) begin
      n.mode[15:8] = avs_writedata[15:8] & MODE_WMASK[15:8];
    end

    // Master control: stop beats restart beats start beats abort
    if (lo && avs_address == REG_MCTRL) begin
      n.ack_val = wd[CTL_ACK];
      if (wd[CTL_STOP]) begin
        n.start = 1'b0;
        if (q.state != ST_IDLE) begin
          n.state = ST_STOP;
          n.phase = PH_LOW0;
        end
      end else if (wd[CTL_RESTART]) begin
        if (q.start) begin
          n.state = ST_RESTART;
          n.phase = PH_LOW0;
        end
      end else if (wd[CTL_START]) begin
        if (en) begin
          n.start = 1'b1;
          n.phase = PH_LOW0;
          if (q.state == ST_IDLE) begin
            n.state = ST_START;
          end else if (q.state == ST_WAIT) begin
            n.state = ST_XFER;
            n.bitn = 4'h0;
            n.is_addr = 1'b0;
            n.shift = q.mtx;
          end
        end
      end else begin
        n.start = 1'b0;
        n.state = ST_IDLE;
      end
    end

    // Disable halts the master and wipes its data registers
    if (q.mode[MODE_EN] && !n.mode[MODE_EN]) begin
      n.mrx = 8'h00;
      n.maddr = 8'h00;
      n.mtx = 8'h00;
      n.ack_val = 1'b0;
      n.start = 1'b0;
    end
    if (!n.mode[MODE_EN] || n.role) begin
      n.state = ST_IDLE;
      n.scl_oe = 1'b0;
      n.sda_oe = 1'b0;
    end

    // Slave: count clock rises per byte, stretch after the ninth
    if (q.role && q.smode[SMODE_EN]) begin
      if (start_seen) begin
        n.s_act = 1'b1;
        n.s_cnt = 4'h0;
      end else if (stop_seen) begin
        n.s_act = 1'b0;
      end else if (q.s_act && scl_rise) begin
        n.s_cnt = q.s_cnt + 4'h1;
        n.s_sh = {q.s_sh[6:0], q.sda_s2};
        if (q.s_cnt == LAST_DATA_IDX) begin
          n.srx = {q.s_sh[6:0], q.sda_s2};
        end
      end else if (q.s_act && scl_fall && q.s_cnt == SLAVE_RISES) begin
        n.s_stretch = 1'b1;
        n.s_cnt = 4'h0;
      end
      if (lo && avs_address == REG_SCTRL && wd[SCTL_RELEASE]) begin
        n.s_stretch = 1'b0;
      end
    end else begin
      n.s_act = 1'b0;
      n.s_stretch = 1'b0;
    end
    if (!n.smode[SMODE_EN]) begin
      n.ssta = 8'h00;
    end
    if (n.role) begin
      n.scl_oe = n.s_stretch;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
      q.mode <= MODE_RESET;
      q.wreq <= 1'b1;
      q.state <= ST_IDLE;
      // Synchronisers start at the idle line level, so no false edge follows reset
      q.sda_s1 <= 1'b1;
      q.sda_s2 <= 1'b1;
      q.sda_d <= 1'b1;
      q.scl_s1 <= 1'b1;
      q.scl_s2 <= 1'b1;
      q.scl_d <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // Outputs straight from the state register, pin levels tied to 0; lines only ever pull low
  assign avs_readdata = q.rdata;
  assign avs_waitrequest = q.wreq;
  assign serial_clock_pin_oe = q.scl_oe;
  assign serial_data_pin_oe = q.sda_oe;
  assign serial_clock_pin_out = 1'b0;
  assign serial_data_pin_out = 1'b0;

endmodule : i2cu_unit

// file: src/i2cu_pkg.sv
// Register map, field layout, timing and state types of the two-wire bus unit
package i2cu_pkg;

  // System clock and register bus address width (word index)
  localparam int CLK_HZ = 100_000_000;
  localparam int ADDR_W = 16;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [15:0] REG_ROLE = 16'hf6c0;
  localparam logic [15:0] REG_MRX = 16'hf6c2;
  localparam logic [15:0] REG_MADDR = 16'hf6c4;
  localparam logic [15:0] REG_MTX = 16'hf6c6;
  localparam logic [15:0] REG_MCTRL = 16'hf6c8;
  localparam logic [15:0] REG_MMODE = 16'hf6ca;
  localparam logic [15:0] REG_MSTA = 16'hf6cc;
  localparam logic [15:0] REG_SRX = 16'hf6ce;
  localparam logic [15:0] REG_SOWN = 16'hf6d0;
  localparam logic [15:0] REG_STX = 16'hf6d2;
  localparam logic [15:0] REG_SCTRL = 16'hf6d4;
  localparam logic [15:0] REG_SMODE = 16'hf6d6;
  localparam logic [15:0] REG_SSTA = 16'hf6d8;

  // Reset value and writable bits of the master mode register
  localparam logic [15:0] MODE_RESET = 16'h0200;
  localparam logic [15:0] MODE_WMASK = 16'h073f;

  // Field positions
  localparam int ROLE_BIT = 0;
  localparam int ADDR_DIR = 0;
  localparam int CTL_START = 0;
  localparam int CTL_STOP = 1;
  localparam int CTL_RESTART = 2;
  localparam int CTL_ACK = 7;
  localparam int MODE_EN = 0;
  localparam int MODE_RATE_LO = 1;
  localparam int MODE_SLOW_LO = 3;
  localparam int MODE_SYNC = 5;
  localparam int MODE_CLK_LO = 8;
  localparam int STA_BUSY = 0;
  localparam int STA_ACK = 1;
  localparam int STA_ERR = 2;
  localparam int SCTL_RELEASE = 5;
  localparam int SCTL_ACK = 7;
  localparam int SMODE_EN = 0;

  // Bus rates and the quarter-bit length in system clocks, rounded up
  localparam int RATE_STD_BPS = 100_000;
  localparam int RATE_FAST_BPS = 400_000;
  localparam int RATE_1M_BPS = 1_000_000;
  localparam int QW = 12;
  localparam logic [QW-1:0] QUARTER_STD = QW'((CLK_HZ + 4 * RATE_STD_BPS - 1) / (4 * RATE_STD_BPS));
  localparam logic [QW-1:0] QUARTER_FAST = QW'((CLK_HZ + 4 * RATE_FAST_BPS - 1) / (4 * RATE_FAST_BPS));
  localparam logic [QW-1:0] QUARTER_1M = QW'((CLK_HZ + 4 * RATE_1M_BPS - 1) / (4 * RATE_1M_BPS));
  localparam logic [1:0] RATE_STD = 2'b00;
  localparam logic [1:0] RATE_FAST = 2'b01;
  localparam logic [QW-1:0] SLOW_PER_STEP = 12'h00a;

  // Bit counts within one byte on the wire
  localparam logic [3:0] LAST_DATA_IDX = 4'h7;
  localparam logic [3:0] ACK_BIT_IDX = 4'h8;
  localparam logic [3:0] SLAVE_RISES = 4'h9;

  // Quarter phases of one bit: two with the clock low, two with it released
  localparam logic [1:0] PH_LOW0 = 2'h0;
  localparam logic [1:0] PH_HIGH0 = 2'h2;
  localparam logic [1:0] PH_HIGH1 = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_XFER = 3'b010,
    ST_WAIT = 3'b011,
    ST_RESTART = 3'b100,
    ST_STOP = 3'b101
  } i2cu_state_t;

endpackage : i2cu_pkg

// file: src/i2cu_bit_timer.sv
// Quarter-bit tick generator for the master: clock select, rate and slow-down
module i2cu_bit_timer import i2cu_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Settings from the mode register
  input wire logic [2:0] clk_sel,
  input wire logic [1:0] rate_sel,
  input wire logic [1:0] slow_sel,
  // Low-speed clock enable, one pulse per low-speed period, same domain
  input wire logic low_speed_tick,
  // Control from the bit engine
  input wire logic run,
  input wire logic clear,
  // One-cycle pulse at the end of each quarter bit
  output logic quarter_tick
);

  typedef struct packed {
    logic [2:0] pre;
    logic [QW-1:0] cnt;
    logic tick;
  } i2cu_tmr_t;

  i2cu_tmr_t q, n;
  logic src, op;
  logic [2:0] mask;
  logic [1:0] slow;
  logic [QW-1:0] base, prod, qlen;

  // The shortest quarter must leave room for the pin synchronisers
  if (QUARTER_1M < 12'h002) begin : g_chk
    $error("System clock too slow for the fastest bus rate");
  end

  // Operating clock prescale, rate base and slow-down
  always_comb begin
    n = q;
    n.tick = 1'b0;
    src = clk_sel[2] ? low_speed_tick : 1'b1;
    case (clk_sel)
      3'b000, 3'b100: mask = 3'h0;
      3'b001, 3'b101: mask = 3'h1;
      3'b111: mask = 3'h7;
      default: mask = 3'h3;
    endcase
    op = src && ((q.pre & mask) == mask);
    case (rate_sel)
      RATE_STD: base = QUARTER_STD;
      RATE_FAST: base = QUARTER_FAST;
      default: base = QUARTER_1M;
    endcase
    slow = clk_sel[2] ? 2'b00 : slow_sel;
    prod = base * {{(QW - 2){1'b0}}, slow};
    qlen = base + prod / SLOW_PER_STEP;
    if (clear) begin
      n.pre = 3'h0;
      n.cnt = '0;
    end else if (run) begin
      if (src) begin
        n.pre = q.pre + 3'h1;
      end
      if (op) begin
        if (q.cnt >= qlen - 12'h001) begin
          n.cnt = '0;
          n.tick = 1'b1;
        end else begin
          n.cnt = q.cnt + 12'h001;
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign quarter_tick = q.tick;

endmodule : i2cu_bit_timer

// file: verif/i2cu_unit_asserts.sv
// Port checker for the two-wire bus unit
module i2cu_unit_asserts import i2cu_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register bus
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Link side
  input wire logic low_speed_tick,
  input wire logic serial_clock_pin_in,
  input wire logic serial_clock_pin_out,
  input wire logic serial_clock_pin_oe,
  input wire logic serial_data_pin_in,
  input wire logic serial_data_pin_out,
  input wire logic serial_data_pin_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // One answer cycle per access, then back to waiting
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ans;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  property p_handshake;
    s_req |=> s_ans;
  endproperty
  a_handshake: assert property (p_handshake)
    else $error("waitrequest answer out of step");
  property p_no_spurious;
    !(avs_read || avs_write) |=> avs_waitrequest;
  endproperty
  a_no_spurious: assert property (p_no_spurious)
    else $error("answer without a request");
  property p_upper_zero;
    avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("read data upper half not zero");
  property p_mode_fields;
    avs_read && !avs_waitrequest && avs_address == REG_MMODE
      |-> avs_readdata[15:11] == 5'h0 && avs_readdata[7:6] == 2'h0;
  endproperty
  a_mode_fields: assert property (p_mode_fields)
    else $error("mode register unused bits set");
  property p_ctrl_wo;
    avs_read && !avs_waitrequest && avs_address == REG_MCTRL |-> avs_readdata[2:1] == 2'h0;
  endproperty
  a_ctrl_wo: assert property (p_ctrl_wo)
    else $error("stop or restart request read back set");
  property p_role_bits;
    avs_read && !avs_waitrequest && avs_address == REG_ROLE |-> avs_readdata[7:1] == 7'h0;
  endproperty
  a_role_bits: assert property (p_role_bits)
    else $error("role register unused bits set");
  property p_open_drain;
    serial_clock_pin_out == 1'b0 && serial_data_pin_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("pin driven high");
  // Abort must let both lines go within three cycles of the write landing
  property p_abort;
    avs_write && !avs_waitrequest && avs_address == REG_MCTRL && avs_byteenable[0]
      && avs_writedata[2:0] == 3'h0 |=> ##[0:2] !serial_clock_pin_oe && !serial_data_pin_oe;
  endproperty
  a_abort: assert property (p_abort)
    else $error("lines not released after abort");
  property p_reset_idle;
    $fell(srst) |-> !serial_clock_pin_oe && !serial_data_pin_oe && avs_waitrequest;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("lines or bus busy after reset");
endmodule : i2cu_unit_asserts

bind i2cu_unit i2cu_unit_asserts i_i2cu_unit_asserts (.clk(clk), .srst(srst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .low_speed_tick(low_speed_tick), .serial_clock_pin_in(serial_clock_pin_in),
  .serial_clock_pin_out(serial_clock_pin_out), .serial_clock_pin_oe(serial_clock_pin_oe),
  .serial_data_pin_in(serial_data_pin_in), .serial_data_pin_out(serial_data_pin_out),
  .serial_data_pin_oe(serial_data_pin_oe));

// file: verif/i2cu_slave_model.sv
// Behavioural bus slave: acks, records bytes, sends a fixed byte
module i2cu_slave_model #(
  parameter logic [7:0] TX_BYTE = 8'hc3
) (
  // Wire levels
  input wire logic scl,
  input wire logic sda,
  // Hold the clock low a while after each fall
  input wire logic stretch,
  // Open-drain pulls
  output logic scl_oe,
  output logic sda_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh = 8'h0;
  logic [7:0] last_byte = 8'h0;
  logic [3:0] cnt = 4'h0;
  logic first = 1'b1;
  logic rd = 1'b0;
  logic ack_seen = 1'b0;
  int nbytes = 0;
  int nstarts = 0;
  int nstops = 0;
  initial scl_oe = 1'b0;
  initial sda_oe = 1'b0;

  // Start and stop are data edges while the clock is high
  always @(negedge sda) if (scl === 1'b1) begin
    cnt = 4'h0;
    first = 1'b1;
    sda_oe = 1'b0;
    nstarts++;
  end
  always @(posedge sda) if (scl === 1'b1 && nstarts > 0) nstops++;

  // Bits taken on the clock rise, most significant first, ninth is ack
  always @(posedge scl) begin
    if (cnt < 4'h8) sh = {sh[6:0], sda};
    else if (rd && !first) ack_seen = sda;
    cnt++;
    if (cnt == 4'h8) begin
      last_byte = sh;
      if (first) rd = sh[0];
    end
    if (cnt == 4'h9) nbytes++;
  end

  // Ack or data bit put out after each fall; releasing means the pull-up wins
  always @(negedge scl) begin
    if (cnt == 4'h9) begin
      cnt = 4'h0;
      first = 1'b0;
    end
    if (cnt == 4'h8) sda_oe = !(rd && !first);
    else sda_oe = rd && !first && !TX_BYTE[3'(4'h7 - cnt)];
    if (stretch) begin
      scl_oe = 1'b1;
      #700 scl_oe = 1'b0;
    end
  end
endmodule : i2cu_slave_model

// file: verif/i2cu_unit_tb.sv
// Self-checking bench of the two-wire bus unit
module i2cu_unit_tb import i2cu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [15:0] a;
    logic [15:0] d;
    logic [3:0] be;
    logic [15:0] e;
  } i2cu_row_t;
  // Rows: address, write data, lanes (0 = read only), expected read
  localparam i2cu_row_t ROWS [16] = '{
    '{REG_MMODE, 16'h0, 4'h0, 16'h0200}, '{REG_ROLE, 16'h0, 4'h0, 16'h0},
    '{REG_MCTRL, 16'h0, 4'h0, 16'h0}, '{REG_ROLE, 16'h1, 4'h1, 16'h1},
    '{REG_ROLE, 16'h0, 4'h1, 16'h0}, '{REG_MRX, 16'hff, 4'h1, 16'h0},
    '{REG_MADDR, 16'ha5, 4'h1, 16'ha5}, '{REG_MTX, 16'h5a, 4'h1, 16'h5a},
    '{REG_MCTRL, 16'h87, 4'h1, 16'h80}, '{16'hf6cb, 16'hff, 4'h1, 16'h0},
    '{REG_MMODE, 16'hffff, 4'h3, 16'h073f}, '{REG_MMODE, 16'h0, 4'h3, 16'h0},
    '{REG_MADDR, 16'h0, 4'h0, 16'h0}, '{REG_MCTRL, 16'h0, 4'h0, 16'h0},
    '{REG_MMODE, 16'hff00, 4'h2, 16'h0700}, '{REG_MCTRL, 16'h1, 4'h1, 16'h0}};
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] avs_address = 16'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [2:0] ls_cnt = 3'h0;
  logic ls_tick;
  logic stretch = 1'b0;
  logic scl_w, sda_w, scl_oe, sda_oe, p_scl_oe, p_sda_oe, scl_o, sda_o;
  logic [15:0] v;
  int mismatches = 0;
  int n_compared = 0;

  always #5 clk = ~clk;
  // Low-speed enable every eight clocks; pull-ups on both wires
  always @(posedge clk) ls_cnt <= ls_cnt + 3'h1;
  assign ls_tick = (ls_cnt == 3'h0);
  assign scl_w = !(scl_oe || p_scl_oe);
  assign sda_w = !(sda_oe || p_sda_oe);

  i2cu_unit i_i2cu_unit (.clk(clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .low_speed_tick(ls_tick),
    .serial_clock_pin_in(scl_w), .serial_clock_pin_out(scl_o), .serial_clock_pin_oe(scl_oe),
    .serial_data_pin_in(sda_w), .serial_data_pin_out(sda_o), .serial_data_pin_oe(sda_oe));
  i2cu_slave_model i_i2cu_slave_model (.scl(scl_w), .sda(sda_w), .stretch(stretch),
    .scl_oe(p_scl_oe), .sda_oe(p_sda_oe));

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Bus access: hold request until waitrequest is sampled low
  task wr(input logic [15:0] a, input logic [15:0] d, input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= {16'h0, d};
    avs_byteenable <= be;
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : wr
  task rchk(input string nm, input logic [15:0] a, input logic [15:0] e);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    v = avs_readdata[15:0];
    avs_read <= 1'b0;
    @(posedge clk);
    chk(nm, e, v);
  endtask : rchk
  // Bounded wait for the partner's byte count, then 60 clocks to settle
  task wait_bytes(input int n);
    int k;
    k = 0;
    while (i_i2cu_slave_model.nbytes < n && k < 4000) begin
      @(posedge clk);
      k++;
    end
    chk("bytes", 16'(n), 16'(i_i2cu_slave_model.nbytes));
    repeat (60) @(posedge clk);
  endtask : wait_bytes
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    end_sim;
  end

  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    foreach (ROWS[i]) begin
      if (ROWS[i].be != 4'h0) wr(ROWS[i].a, ROWS[i].d, ROWS[i].be);
      rchk("reg", ROWS[i].a, ROWS[i].e);
    end
    // Write transfer at the fastest rate
    wr(REG_MMODE, 16'h0007, 4'h3);
    wr(REG_MADDR, 16'h00a0, 4'h1);
    wr(REG_MCTRL, 16'h0001, 4'h1);
    wait_bytes(1);
    chk("addr", 16'h00a0, {8'h0, i_i2cu_slave_model.last_byte});
    rchk("echo", REG_MRX, 16'h00a0);
    rchk("busy", REG_MSTA, 16'h0001);
    wr(REG_MTX, 16'h003c, 4'h1);
    wr(REG_MCTRL, 16'h0001, 4'h1);
    wait_bytes(2);
    chk("data", 16'h003c, {8'h0, i_i2cu_slave_model.last_byte});
    rchk("echo", REG_MRX, 16'h003c);
    wr(REG_MCTRL, 16'h0002, 4'h1);
    repeat (300) @(posedge clk);
    chk("stops", 16'h1, 16'(i_i2cu_slave_model.nstops));
    rchk("ctrl", REG_MCTRL, 16'h0);
    rchk("free", REG_MSTA, 16'h0);
    // Read transfer, clock synchronised against a stretching partner
    stretch <= 1'b1;
    wr(REG_MMODE, 16'h0027, 4'h3);
    wr(REG_MADDR, 16'h00a1, 4'h1);
    wr(REG_MCTRL, 16'h0001, 4'h1);
    wait_bytes(3);
    wr(REG_MCTRL, 16'h0081, 4'h1);
    wait_bytes(4);
    rchk("rx", REG_MRX, 16'h00c3);
    chk("ack", 16'h1, {15'h0, i_i2cu_slave_model.ack_seen});
    wr(REG_MCTRL, 16'h0085, 4'h1);
    wait_bytes(5);
    chk("restart", 16'h3, 16'(i_i2cu_slave_model.nstarts));
    chk("readdr", 16'h00a1, {8'h0, i_i2cu_slave_model.last_byte});
    wr(REG_MCTRL, 16'h0000, 4'h1);
    // Lines settle one cycle after the abort lands; look away from the edge
    @(negedge clk);
    chk("release", 16'h0, {14'h0, scl_oe, sda_oe});
    // Second reset in mid-run
    @(posedge clk);
    stretch <= 1'b0;
    srst <= 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rchk("mode", REG_MMODE, 16'h0200);
    rchk("addr0", REG_MADDR, 16'h0);
    end_sim;
  end
endmodule : i2cu_unit_tb
